// ---- logic/thermal_throttle_perf_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module thermal_throttle_perf_control #(
    parameter int STEP_CYC = perf_pkg::STEP_CYCLES,
    parameter int HOLD_TICKS = perf_pkg::MOD_HOLD_TICKS
)(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [7:0] die_temp,
    input wire logic [2:0] active_cpus,
    input wire logic [7:0] est_current,
    input wire logic [7:0] est_power,
    input wire logic [7:0] workload_demand,
    output logic [perf_pkg::RATIO_W-1:0] cpu_ratio,
    output logic [perf_pkg::RATIO_W-1:0] gfx_ratio,
    output logic [7:0] cpu_vid,
    output logic [7:0] gfx_vid,
    output logic clock_run,
    output logic catastrophic_trip_n,
    output logic irq
);
    import perf_pkg::*;

    localparam int TW = $clog2(STEP_CYC + 1);
    localparam int HW = $clog2(HOLD_TICKS + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(STEP_CYC - 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_TICKS);

    if (STEP_CYC < 1 || HOLD_TICKS < 1)
        $error("thermal_throttle_perf_control: counts must be positive");

    function automatic logic [7:0] clip(input logic [7:0] v,
        input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] r;
        r = v;
        if (r < lo)
            r = lo;
        if (r > hi)
            r = hi;
        return r;
    endfunction

    function automatic logic [7:0] to_vid(input logic [7:0] ratio);
        return ratio + VID_OFFSET;
    endfunction

    logic [31:0] ctrl_q;
    logic [31:0] host_q;
    logic [31:0] limit_q;
    logic [31:0] ceil_q;
    logic [EV_W-1:0] irq_stat_q;
    logic [EV_W-1:0] irq_stat_d;
    logic [EV_W-1:0] irq_mask_q;
    logic [EV_W-1:0] ev;
    logic [TW-1:0] tick_cnt_q;
    logic tick_q;
    logic [HW-1:0] hold_q;
    logic [9:0] hist_q;
    logic engaged_q;
    gov_e state_q;
    gov_e state_d;
    logic [7:0] threshold;
    logic engage_hot;
    logic trip_hot;
    logic over_limit;
    logic boost_entry;
    logic boost_stay;
    logic [7:0] host_min;
    logic [7:0] host_max;
    logic [7:0] host_req;
    logic [7:0] norm_max;
    logic [7:0] normal_target;
    logic [7:0] cpu_ceiling;
    logic [7:0] cpu_ceil;
    logic throttling;
    logic mod_run;
    logic [31:0] status;

    step_if cpu_s();
    step_if gfx_s();

    ratio_stepper #(
        .RESET_RATIO(BASE_RATIO)
    ) u_cpu_step (
        .clock(clock),
        .rstn(rstn),
        .s(cpu_s)
    );

    ratio_stepper #(
        .RESET_RATIO(GFX_BASE_RATIO)
    ) u_gfx_step (
        .clock(clock),
        .rstn(rstn),
        .s(gfx_s)
    );

    clock_modulator #(
        .SLOT_CYCLES(MOD_SLOT_CYCLES),
        .SLOTS(MOD_SLOTS),
        .RUN_SLOTS(MOD_RUN_SLOTS)
    ) u_mod (
        .clock(clock),
        .rstn(rstn),
        .enable(state_q == GOV_MODULATE),
        .run(mod_run)
    );

    assign host_req = host_q[HOST_REQ_LSB +: 8];
    assign host_min = host_q[HOST_MIN_LSB +: 8];
    assign host_max = host_q[HOST_MAX_LSB +: 8];
    // Offset is only subtracted, so the threshold never rises above default
    assign threshold = ACT_DEFAULT_C
        - {2'b00, ctrl_q[CTRL_OFFS_LSB +: OFFS_W]};
    assign engage_hot = die_temp >= threshold;
    assign trip_hot = die_temp >= TRIP_C;
    assign over_limit = est_current >= limit_q[LIM_CUR_LSB +: 8]
        || est_power >= limit_q[LIM_PWR_LSB +: 8];
    assign boost_stay = ctrl_q[CTRL_BOOST_BIT] && host_req == PERF_HIGHEST;
    assign boost_entry = boost_stay && !over_limit && !engage_hot;
    assign throttling = state_q == GOV_THROTTLE || state_q == GOV_MODULATE;
    assign cpu_ceiling = (active_cpus <= 3'd1) ? ceil_q[7:0]
        : (active_cpus == 3'd2) ? ceil_q[15:8]
        : (active_cpus == 3'd3) ? ceil_q[23:16] : ceil_q[31:24];

    // Host limits bound the pick; only boost may run above base
    assign norm_max = (host_max > BASE_RATIO) ? BASE_RATIO : host_max;
    assign normal_target = ctrl_q[CTRL_AUTO_BIT]
        ? clip(hist_q[9:2], host_min, norm_max)
        : clip(host_req, host_min, norm_max);

    always_comb
    begin
        if (state_q == GOV_BOOST)
            cpu_ceil = over_limit ? cpu_s.ratio : cpu_ceiling;
        else
            cpu_ceil = normal_target;
    end

    assign cpu_s.tick = tick_q;
    assign cpu_s.down = throttling;
    assign cpu_s.floor_r = MIN_RATIO;
    assign cpu_s.ceil_r = cpu_ceil;
    assign gfx_s.tick = tick_q;
    assign gfx_s.down = throttling;
    assign gfx_s.floor_r = MIN_RATIO;
    assign gfx_s.ceil_r = host_q[HOST_GFX_LSB +: 8];

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= tick_cnt_q == TICK_LAST;
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // Demand history: weighted three quarters old, one quarter new
    always_ff @(posedge clock)
    begin
        if (!rstn)
            hist_q <= {BASE_RATIO, 2'b00};
        else if (tick_q)
            hist_q <= 10'(({2'b00, hist_q} * 12'd3
                + {2'b00, workload_demand, 2'b00}) >> 2);
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            GOV_NORMAL:
                if (engage_hot)
                    state_d = GOV_THROTTLE;
                else if (boost_entry)
                    state_d = GOV_BOOST;
            GOV_BOOST:
                if (engage_hot)
                    state_d = GOV_THROTTLE;
                else if (!boost_stay)
                    state_d = GOV_NORMAL;
            GOV_THROTTLE:
                if (!engage_hot)
                    state_d = GOV_NORMAL;
                else if (hold_q == HOLD_LAST)
                    state_d = GOV_MODULATE;
            GOV_MODULATE:
                if (!engage_hot)
                    state_d = GOV_NORMAL;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
            state_q <= GOV_NORMAL;
        else
            state_q <= state_d;
    end

    // Modulation waits until stepping alone has run out of room
    always_ff @(posedge clock)
    begin
        if (!rstn || state_q != GOV_THROTTLE || cpu_s.ratio > MIN_RATIO)
            hold_q <= '0;
        else if (tick_q && hold_q != HOLD_LAST)
            hold_q <= hold_q + 1'b1;
    end

    // Latched: a hot die must not be allowed to restart by cooling briefly
    always_ff @(posedge clock)
    begin
        if (!rstn)
            catastrophic_trip_n <= 1'b1;
        else if (trip_hot)
            catastrophic_trip_n <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            cpu_ratio <= BASE_RATIO;
            gfx_ratio <= GFX_BASE_RATIO;
            cpu_vid <= to_vid(BASE_RATIO);
            gfx_vid <= to_vid(GFX_BASE_RATIO);
            clock_run <= 1'b1;
        end
        else
        begin
            cpu_ratio <= cpu_s.ratio;
            gfx_ratio <= gfx_s.ratio;
            cpu_vid <= to_vid(cpu_s.ratio);
            gfx_vid <= to_vid(gfx_s.ratio);
            clock_run <= mod_run;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ctrl_q <= CTRL_RST;
            host_q <= HOST_RST;
            limit_q <= LIMIT_RST;
            ceil_q <= CEIL_RST;
            irq_mask_q <= '0;
        end
        else if (wr)
        begin
            if (addr == REG_CTRL)
                ctrl_q <= wdata;
            if (addr == REG_HOST)
                host_q <= wdata;
            if (addr == REG_LIMIT)
                limit_q <= wdata;
            if (addr == REG_CEIL)
                ceil_q <= wdata;
            if (addr == REG_IRQ_MASK)
                irq_mask_q <= wdata[EV_W-1:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
            engaged_q <= 1'b0;
        else
            engaged_q <= engage_hot;
    end

    always_comb
    begin
        ev = '0;
        ev[EV_ENGAGE] = engage_hot && !engaged_q;
        ev[EV_RELEASE] = !engage_hot && engaged_q;
        ev[EV_CLKMOD] = state_d == GOV_MODULATE && state_q != GOV_MODULATE;
        ev[EV_TRIP] = trip_hot && catastrophic_trip_n;
        ev[EV_BOOST] = state_d == GOV_BOOST && state_q != GOV_BOOST;
        irq_stat_d = irq_stat_q;
        if (wr && addr == REG_IRQ_STAT)
            irq_stat_d = irq_stat_d & ~wdata[EV_W-1:0];
        // A new event beats a clear in the same cycle
        irq_stat_d = irq_stat_d | ev;
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    always_comb
    begin
        status = '0;
        status[7:0] = cpu_s.ratio;
        status[ST_GFX_LSB +: 8] = gfx_s.ratio;
        status[ST_STATE_LSB +: 2] = state_q;
        status[ST_ENGAGED_BIT] = engaged_q;
        status[ST_RUN_BIT] = clock_run;
        status[ST_TRIP_BIT] = !catastrophic_trip_n;
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
            rdata <= '0;
        else if (rd)
        begin
            unique case (addr)
                REG_CTRL: rdata <= ctrl_q;
                REG_HOST: rdata <= host_q;
                REG_LIMIT: rdata <= limit_q;
                REG_CEIL: rdata <= ceil_q;
                REG_STATUS: rdata <= status;
                REG_IRQ_STAT: rdata <= {{(32-EV_W){1'b0}}, irq_stat_q};
                REG_IRQ_MASK: rdata <= {{(32-EV_W){1'b0}}, irq_mask_q};
                default: rdata <= '0;
            endcase
        end
        else
            rdata <= '0;
    end
endmodule
`default_nettype wire

// ---- logic/perf_pkg.sv ----
`default_nettype none
package perf_pkg;
    localparam int RATIO_W = 8;
    localparam int CLK_PERIOD_NS = 25;
    localparam int STEP_TIME_NS = 1000;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int MOD_SLOT_NS = 250;
    localparam int MOD_SLOT_CYCLES = MOD_SLOT_NS / CLK_PERIOD_NS;
    localparam int MOD_SLOTS = 4;
    localparam int MOD_RUN_SLOTS = 1;
    localparam int MOD_HOLD_TICKS = 4;
    localparam int RATIO_STEP_MHZ = 100;
    localparam logic [7:0] ACT_DEFAULT_C = 8'h64;
    localparam logic [7:0] TRIP_C = 8'h7d;
    localparam logic [7:0] MIN_RATIO = 8'h08;
    localparam logic [7:0] BASE_RATIO = 8'h18;
    localparam logic [7:0] GFX_BASE_RATIO = 8'h0c;
    localparam logic [7:0] PERF_HIGHEST = 8'hff;
    localparam logic [7:0] VID_OFFSET = 8'h20;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HOST = 8'h04;
    localparam logic [7:0] REG_LIMIT = 8'h08;
    localparam logic [7:0] REG_CEIL = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_STAT = 8'h14;
    localparam logic [7:0] REG_IRQ_MASK = 8'h18;
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_BOOST_BIT = 1;
    localparam int CTRL_OFFS_LSB = 8;
    localparam int OFFS_W = 6;
    localparam int HOST_REQ_LSB = 0;
    localparam int HOST_MIN_LSB = 8;
    localparam int HOST_MAX_LSB = 16;
    localparam int HOST_GFX_LSB = 24;
    localparam int LIM_CUR_LSB = 0;
    localparam int LIM_PWR_LSB = 8;
    localparam int ST_GFX_LSB = 8;
    localparam int ST_STATE_LSB = 16;
    localparam int ST_ENGAGED_BIT = 18;
    localparam int ST_RUN_BIT = 19;
    localparam int ST_TRIP_BIT = 20;
    localparam logic [31:0] CTRL_RST = 32'h0000_0002;
    localparam logic [31:0] HOST_RST = 32'h0c30_0818;
    localparam logic [31:0] LIMIT_RST = 32'h0000_c8c8;
    localparam logic [31:0] CEIL_RST = 32'h1e20_2428;
    localparam int EV_ENGAGE = 0;
    localparam int EV_RELEASE = 1;
    localparam int EV_CLKMOD = 2;
    localparam int EV_TRIP = 3;
    localparam int EV_BOOST = 4;
    localparam int EV_W = 5;
    typedef enum logic [1:0]
    {
        GOV_NORMAL = 2'b00,
        GOV_BOOST = 2'b01,
        GOV_THROTTLE = 2'b10,
        GOV_MODULATE = 2'b11
    } gov_e;
endpackage
`default_nettype wire

// ---- logic/step_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface step_if;
    logic tick;
    logic down;
    logic [perf_pkg::RATIO_W-1:0] floor_r;
    logic [perf_pkg::RATIO_W-1:0] ceil_r;
    logic [perf_pkg::RATIO_W-1:0] ratio;
    modport ctrl(output tick, output down, output floor_r, output ceil_r,
        input ratio);
    modport stepper(input tick, input down, input floor_r, input ceil_r,
        output ratio);
endinterface
`default_nettype wire

// ---- logic/ratio_stepper.sv ----
`timescale 1ns/1ps
`default_nettype none
module ratio_stepper #(
    parameter logic [perf_pkg::RATIO_W-1:0] RESET_RATIO = perf_pkg::BASE_RATIO
)(
    input wire logic clock,
    input wire logic rstn,
    step_if.stepper s
);
    import perf_pkg::*;

    logic [RATIO_W-1:0] ratio_q;

    // One ratio unit per tick in either direction, never a jump
    always_ff @(posedge clock)
    begin
        if (!rstn)
            ratio_q <= RESET_RATIO;
        else if (s.tick)
        begin
            if (s.down && ratio_q > s.floor_r)
                ratio_q <= ratio_q - 8'h01;
            else if (!s.down && ratio_q < s.ceil_r)
                ratio_q <= ratio_q + 8'h01;
            else if (ratio_q > s.ceil_r)
                ratio_q <= ratio_q - 8'h01;
        end
    end

    assign s.ratio = ratio_q;
endmodule
`default_nettype wire

// ---- logic/clock_modulator.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_modulator #(
    parameter int SLOT_CYCLES = perf_pkg::MOD_SLOT_CYCLES,
    parameter int SLOTS = perf_pkg::MOD_SLOTS,
    parameter int RUN_SLOTS = perf_pkg::MOD_RUN_SLOTS
)(
    input wire logic clock,
    input wire logic rstn,
    input wire logic enable,
    output logic run
);
    import perf_pkg::*;

    localparam int CW = $clog2(SLOT_CYCLES + 1);
    localparam int SW = $clog2(SLOTS + 1);
    localparam logic [CW-1:0] CYC_LAST = CW'(SLOT_CYCLES - 1);
    localparam logic [SW-1:0] SLOT_LAST = SW'(SLOTS - 1);
    localparam logic [SW-1:0] RUN_LIM = SW'(RUN_SLOTS);

    logic [CW-1:0] cyc_q;
    logic [SW-1:0] slot_q;

    if (SLOT_CYCLES < 1 || RUN_SLOTS < 1 || RUN_SLOTS >= SLOTS)
        $error("clock_modulator: bad duty parameters");

    always_ff @(posedge clock)
    begin
        if (!rstn || !enable)
        begin
            cyc_q <= '0;
            slot_q <= '0;
        end
        else if (cyc_q == CYC_LAST)
        begin
            cyc_q <= '0;
            slot_q <= (slot_q == SLOT_LAST) ? '0 : slot_q + 1'b1;
        end
        else
            cyc_q <= cyc_q + 1'b1;
    end

    // Run one slot in four, stop three; free running when not enabled
    always_ff @(posedge clock)
    begin
        if (!rstn)
            run <= 1'b1;
        else
            run <= !enable || (slot_q < RUN_LIM);
    end
endmodule
`default_nettype wire

// ---- verification/thermal_throttle_perf_control_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module thermal_throttle_perf_control_monitor
    import perf_pkg::*;
#(
    parameter int STEP_CYC = perf_pkg::STEP_CYCLES,
    parameter int HOLD_TICKS = perf_pkg::MOD_HOLD_TICKS
)(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [7:0] die_temp,
    input wire logic [2:0] active_cpus,
    input wire logic [7:0] est_current,
    input wire logic [7:0] est_power,
    input wire logic [7:0] workload_demand,
    input wire logic [7:0] cpu_ratio,
    input wire logic [7:0] gfx_ratio,
    input wire logic [7:0] cpu_vid,
    input wire logic [7:0] gfx_vid,
    input wire logic clock_run,
    input wire logic catastrophic_trip_n,
    input wire logic irq
);
    logic [7:0] offs_q;
    logic hot;
    // Offset shadow follows the same write the device latches
    always_ff @(posedge clock)
    begin
        if (!rstn)
            offs_q <= 8'h00;
        else if (wr && addr == REG_CTRL)
            offs_q <= {2'h0, wdata[13:8]};
    end
    assign hot = die_temp >= (ACT_DEFAULT_C - offs_q);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Delays assume the short step interval used in simulation
    sequence s_hot_hold;
        (hot && cpu_ratio > MIN_RATIO) ##1 hot [*6];
    endsequence
    sequence s_cool;
        (!hot) [*4];
    endsequence
    property p_engage;
        s_hot_hold |-> cpu_ratio < $past(cpu_ratio, 6);
    endproperty
    property p_release;
        s_cool |-> clock_run;
    endproperty
    property p_mod_floor;
        !clock_run |-> $past(cpu_ratio, 3) == MIN_RATIO;
    endproperty
    property p_duty;
        $fell(clock_run) |-> $past(clock_run, 10);
    endproperty
    property p_vid;
        cpu_vid == cpu_ratio + VID_OFFSET && gfx_vid == gfx_ratio + VID_OFFSET;
    endproperty
    property p_step;
        // The reset load itself is a jump, so skip the edges around release
        $past(rstn) && $changed(cpu_ratio)
            |-> cpu_ratio == $past(cpu_ratio) + 8'h01
            || cpu_ratio == $past(cpu_ratio) - 8'h01;
    endproperty
    property p_trip;
        die_temp >= TRIP_C |=> !catastrophic_trip_n;
    endproperty
    property p_trip_hold;
        !catastrophic_trip_n |=> !catastrophic_trip_n;
    endproperty
    property p_trip_cause;
        $fell(catastrophic_trip_n) |-> $past(die_temp) >= TRIP_C;
    endproperty
    a_engage: assert property (p_engage)
        else $error("ratio did not step down while hot");
    a_release: assert property (p_release)
        else $error("clocks still gated after cooling");
    a_mod_floor: assert property (p_mod_floor)
        else $error("clock gating above ratio floor");
    a_duty: assert property (p_duty)
        else $error("running phase shorter than a quarter");
    a_vid: assert property (p_vid)
        else $error("voltage code does not track ratio");
    a_step: assert property (p_step)
        else $error("ratio moved by more than one unit");
    a_trip: assert property (p_trip)
        else $error("trip output not asserted");
    a_trip_hold: assert property (p_trip_hold)
        else $error("trip output released before reset");
    a_trip_cause: assert property (p_trip_cause)
        else $error("trip without temperature cause");
endmodule
bind thermal_throttle_perf_control thermal_throttle_perf_control_monitor #(
    .STEP_CYC(STEP_CYC),
    .HOLD_TICKS(HOLD_TICKS)
) i_mon (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .die_temp(die_temp), .active_cpus(active_cpus),
    .est_current(est_current), .est_power(est_power),
    .workload_demand(workload_demand), .cpu_ratio(cpu_ratio),
    .gfx_ratio(gfx_ratio), .cpu_vid(cpu_vid), .gfx_vid(gfx_vid),
    .clock_run(clock_run), .catastrophic_trip_n(catastrophic_trip_n),
    .irq(irq)
);
`default_nettype wire

// ---- verification/power_sequencer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module power_sequencer_model #(
    parameter logic [7:0] CRIT_C = 8'h78
)(
    input wire logic clock,
    input wire logic rstn,
    input wire logic catastrophic_trip_n,
    input wire logic [7:0] die_temp,
    output logic power_off,
    output logic os_shutdown
);
    // Power removal latches; only a platform reset brings it back
    always_ff @(posedge clock)
    begin
        if (!rstn)
            power_off <= 1'b0;
        else if (!catastrophic_trip_n)
            power_off <= 1'b1;
    end
    always_ff @(posedge clock)
    begin
        if (!rstn)
            os_shutdown <= 1'b0;
        else if (die_temp >= CRIT_C)
            os_shutdown <= 1'b1;
    end
endmodule
`default_nettype wire

// ---- verification/thermal_throttle_perf_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module thermal_throttle_perf_control_tb_top;
    import perf_pkg::*;
    logic clock, rstn, wr, rd, clock_run, trip_n, irq, power_off, os_down;
    logic [7:0] addr, die_temp, est_current, est_power, demand;
    logic [7:0] cpu_ratio, gfx_ratio, cpu_vid, gfx_vid;
    logic [31:0] wdata, rdata;
    logic [2:0] active_cpus;
    int n_fail = 0;
    int tests_run = 0;
    int cnt;
    thermal_throttle_perf_control #(.STEP_CYC(2), .HOLD_TICKS(1)) i_dut (
        .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .die_temp(die_temp),
        .active_cpus(active_cpus), .est_current(est_current),
        .est_power(est_power), .workload_demand(demand),
        .cpu_ratio(cpu_ratio), .gfx_ratio(gfx_ratio), .cpu_vid(cpu_vid),
        .gfx_vid(gfx_vid), .clock_run(clock_run),
        .catastrophic_trip_n(trip_n), .irq(irq)
    );
    power_sequencer_model i_seq (
        .clock(clock), .rstn(rstn), .catastrophic_trip_n(trip_n),
        .die_temp(die_temp), .power_off(power_off), .os_shutdown(os_down)
    );
    task automatic results();
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial
    begin
        #(25 * 3000);
        n_fail++;
        results();
    end
    initial
    begin
        rstn = 1'b0;
        {addr, wdata, wr, rd, est_current, est_power, demand} = '0;
        die_temp = 8'h28;
        active_cpus = 3'h4;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        #1 chk({cpu_ratio, gfx_ratio, cpu_vid, gfx_vid},
            {BASE_RATIO, GFX_BASE_RATIO, 8'h38, 8'h2c});
        chk({clock_run, trip_n, irq}, 3'h6);
        rchk(REG_CTRL, CTRL_RST);
        rchk(REG_HOST, HOST_RST);
        rchk(REG_LIMIT, LIMIT_RST);
        rchk(REG_CEIL, CEIL_RST);
        rchk(REG_IRQ_MASK, 32'h0);
        rchk(8'h1c, 32'h0);
        rchk(REG_STATUS, 32'h0008_0c18);
        wreg(REG_IRQ_MASK, 32'h1f);
        // Current estimate at its limit must block the boost entry
        est_current <= 8'hc8;
        wreg(REG_HOST, 32'h0c30_08ff);
        cyc(20);
        rchk(REG_IRQ_STAT, 32'h0);
        est_current <= 8'h00;
        cyc(4);
        chk(irq, 1'b1);
        rchk(REG_IRQ_STAT, 32'h10);
        cyc(40);
        chk(cpu_ratio, 8'h1e);
        active_cpus <= 3'h1;
        cyc(40);
        chk(cpu_ratio, 8'h28);
        active_cpus <= 3'h3;
        cyc(24);
        chk(cpu_ratio, 8'h20);
        active_cpus <= 3'h2;
        cyc(20);
        chk(cpu_ratio, 8'h24);
        // Power at its limit freezes the climb where it stands
        est_power <= 8'hc8;
        active_cpus <= 3'h1;
        cyc(20);
        chk(cpu_ratio, 8'h24);
        rchk(REG_STATUS, 32'h0009_0c24);
        est_power <= 8'h00;
        wreg(REG_IRQ_STAT, 32'h10);
        cyc(2);
        chk(irq, 1'b0);
        wreg(REG_HOST, HOST_RST);
        cyc(50);
        chk(cpu_ratio, BASE_RATIO);
        // Offset 10 puts the threshold at 90: one degree below stays idle
        wreg(REG_CTRL, 32'h0000_0a02);
        die_temp <= 8'h59;
        cyc(10);
        rchk(REG_IRQ_STAT, 32'h0);
        die_temp <= 8'h5a;
        cyc(3);
        chk(irq, 1'b1);
        cyc(60);
        chk(cpu_ratio, MIN_RATIO);
        chk(gfx_ratio < GFX_BASE_RATIO, 1'b1);
        rchk(REG_IRQ_STAT, 32'h05);
        cnt = 0;
        repeat (40)
        begin
            @(posedge clock);
            #1 cnt += int'(clock_run);
        end
        chk(cnt, 10);
        die_temp <= 8'h50;
        cyc(5);
        chk(clock_run, 1'b1);
        rchk(REG_IRQ_STAT, 32'h07);
        wreg(REG_IRQ_STAT, 32'h07);
        wreg(REG_CTRL, 32'h0000_0003);
        demand <= 8'hff;
        cyc(200);
        chk(cpu_ratio, BASE_RATIO);
        demand <= 8'h00;
        cyc(250);
        chk(cpu_ratio, MIN_RATIO);
        die_temp <= 8'h78;
        cyc(3);
        chk({os_down, trip_n}, 2'h3);
        die_temp <= 8'h7d;
        cyc(3);
        chk({trip_n, power_off, irq}, 3'h3);
        die_temp <= 8'h28;
        cyc(5);
        chk(trip_n, 1'b0);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        #1 chk({trip_n, power_off}, 2'h2);
        results();
    end
endmodule
`default_nettype wire
